// >>> hw/tam_alarm_monitor.sv
// What this block does
// - Below level one threshold: no alarm output
// - Level one closes contact, lights LED, logs
// - Level two adds line processing, yellow alarm
// - Hook off output follows control SW bit only
// - Threshold codes 3..9 only, else rejected
// - Code n means rate ten to minus n
// - Duration range limited per threshold code
// - Per level duration 1..3600 seconds
// - Self clear at window end, else command
// - Clear drops contact, LED, logs, supervision
// - No self clear: supervision ends with condition
// - Alarm when window errors exceed threshold
// - Activation resets counter, starts new window
// - Repeat violation extends alarm full window
// - Frame slips over threshold raise level two
// - Slip counter reset each counting period
// - Factory defaults 6/10s, 5/10s, 5 per 2h
// - Zero code, duration, threshold or hours field write keeps current value
// - Self clearing enable, default on
// - Condition clear ends line processing, yellow
//
// The placing of the registers and the APB slave port were chosen for this implementation.
module tam_alarm_monitor
	import tam_pkg::*;
#(
	parameter int TICK_CYC = TAM_TICK_CYC
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Carrier events
	input  wire logic        bit_err_in,
	input  wire logic        slip_in,
	// Alarm outputs
	output logic             contact_out,
	output logic             red_led_out,
	output logic             yellow_out,
	output logic             line_proc_out,
	output logic             hook_off_out,
	output logic [1:0]       alarm_level_out,
	// Log events
	output logic             log_alarm_out,
	output logic [1:0]       log_alarm_lvl_out,
	output logic             log_clear_out
);

	// ==========================================================
	// Functions
	function automatic logic [11:0] dur_lo(input logic [3:0] code);
		case (code)
			4'h7:    dur_lo = 12'h00a;
			4'h8:    dur_lo = 12'h064;
			4'h9:    dur_lo = 12'h3e8;
			default: dur_lo = 12'h001;
		endcase
	endfunction : dur_lo

	function automatic logic [11:0] dur_hi(input logic [3:0] code);
		case (code)
			4'h3:    dur_hi = 12'h015;
			4'h4:    dur_hi = 12'h0da;
			4'h5:    dur_hi = 12'h864;
			default: dur_hi = TAM_DUR_MAX;
		endcase
	endfunction : dur_hi

	function automatic logic cfg_ok(input tam_cfg_s c);
		cfg_ok = (c.code >= TAM_CODE_MIN) && (c.code <= TAM_CODE_MAX) &&
			(c.dur >= dur_lo(c.code)) && (c.dur <= dur_hi(c.code));
	endfunction : cfg_ok

	// Allowed errors in one window: rate 1.5e6 / 10^code times seconds
	function automatic logic [31:0] err_limit(input tam_cfg_s c);
		logic [31:0] d;
		d = {20'h00000, c.dur};
		case (c.code)
			4'h3:    err_limit = d * 32'h0000_05dc;
			4'h4:    err_limit = d * 32'h0000_0096;
			4'h5:    err_limit = d * 32'h0000_000f;
			4'h6:    err_limit = (d * 32'h0000_0003) / 32'h0000_0002;
			4'h7:    err_limit = (d * 32'h0000_0003) / 32'h0000_0014;
			4'h8:    err_limit = (d * 32'h0000_0003) / 32'h0000_00c8;
			default: err_limit = (d * 32'h0000_0003) / 32'h0000_07d0;
		endcase
	endfunction : err_limit

	// Zero field keeps the stored value
	function automatic tam_cfg_s merge_cfg(input tam_cfg_s old, input logic [31:0] w);
		tam_cfg_s n;
		n.code = w[TAM_CODE_LSB +: 4];
		n.dur  = w[TAM_DUR_LSB +: 12];
		if (n.code == 4'h0)
			n.code = old.code;
		if (n.dur == 12'h000)
			n.dur = old.dur;
		merge_cfg = n;
	endfunction : merge_cfg

	// ==========================================================
	// Registers
	tam_cfg_s      cfg_q [2];
	tam_slip_cfg_s slip_cfg_q;
	logic          self_clr_q;
	logic          hook_sel_q;
	logic          inval_q;
	logic [25:0]   tick_cnt_q;
	logic          tick_q;
	logic [31:0]   err_cnt_q [2];
	logic [11:0]   win_sec_q [2];
	logic          act_q [2];
	logic          cond_q [2];
	logic [7:0]    slip_cnt_q;
	logic [11:0]   slip_sec_q;
	logic [4:0]    slip_hr_q;
	logic          pready_q;
	logic          pslverr_q;
	logic [31:0]   prdata_q;
	logic          log_alarm_q;
	logic [1:0]    log_lvl_q;
	logic          log_clear_q;

	// ==========================================================
	// APB decode
	wire logic    apb_acc   = psel_in && penable_in;
	wire logic    apb_done  = apb_acc && pready_q;
	wire logic    wr_done   = apb_done && pwrite_in;
	wire logic    sel_l1    = paddr_in == TAM_OFS_L1_CFG;
	wire logic    sel_l2    = paddr_in == TAM_OFS_L2_CFG;
	wire logic    sel_slip  = paddr_in == TAM_OFS_SLIP_CFG;
	wire logic    sel_ctrl  = paddr_in == TAM_OFS_CTRL;
	wire logic    sel_stat  = paddr_in == TAM_OFS_STATUS;
	wire logic    sel_c1    = paddr_in == TAM_OFS_L1_CNT;
	wire logic    sel_c2    = paddr_in == TAM_OFS_L2_CNT;
	wire logic    sel_sc    = paddr_in == TAM_OFS_SLIP_CNT;
	wire logic    sel_any   = sel_l1 || sel_l2 || sel_slip || sel_ctrl || sel_stat ||
		sel_c1 || sel_c2 || sel_sc;
	wire tam_cfg_s new_l1   = merge_cfg(cfg_q[0], pwdata_in);
	wire tam_cfg_s new_l2   = merge_cfg(cfg_q[1], pwdata_in);
	wire logic [7:0] new_thr = (pwdata_in[TAM_SLTHR_LSB +: 8] == 8'h00) ?
		slip_cfg_q.thr : pwdata_in[TAM_SLTHR_LSB +: 8];
	wire logic [4:0] new_hrs = (pwdata_in[TAM_SLHRS_LSB +: 5] == 5'h00) ?
		slip_cfg_q.hrs : pwdata_in[TAM_SLHRS_LSB +: 5];
	wire logic    ok_l1     = cfg_ok(new_l1);
	wire logic    ok_l2     = cfg_ok(new_l2);
	wire logic    ok_slip   = new_hrs <= TAM_HRS_MAX;
	wire logic    bad_wr    = pwrite_in && ((sel_l1 && !ok_l1) || (sel_l2 && !ok_l2) ||
		(sel_slip && !ok_slip));
	wire logic    wr_reject = wr_done && bad_wr;
	wire logic    op_clear  = wr_done && sel_ctrl && pwdata_in[TAM_CTRL_CLR];
	wire logic    inval_clr = wr_done && sel_stat && pwdata_in[TAM_ST_INVAL];

	// ==========================================================
	// Alarm detection
	wire logic [31:0] lim [2];
	wire logic        exceed [2];
	wire logic        win_end [2];
	wire logic        slip_over;
	wire logic        slip_end;
	wire logic        trig [2];
	wire logic        rise_any;
	wire tam_level_e  level;

	assign lim[0]     = err_limit(cfg_q[0]);
	assign lim[1]     = err_limit(cfg_q[1]);
	assign exceed[0]  = err_cnt_q[0] > lim[0];
	assign exceed[1]  = err_cnt_q[1] > lim[1];
	assign win_end[0] = tick_q && (win_sec_q[0] >= cfg_q[0].dur - 12'h001);
	assign win_end[1] = tick_q && (win_sec_q[1] >= cfg_q[1].dur - 12'h001);
	assign slip_over  = slip_cnt_q > slip_cfg_q.thr;
	assign slip_end   = tick_q && (slip_sec_q == TAM_SEC_PER_HR - 12'h001) &&
		(slip_hr_q >= slip_cfg_q.hrs - 5'h01);
	assign trig[0]    = exceed[0];
	assign trig[1]    = exceed[1] || slip_over;
	assign rise_any   = (trig[0] && !act_q[0]) || (trig[1] && !act_q[1]);

	assign level = act_q[1] ? TAM_LVL_MAJOR : (act_q[0] ? TAM_LVL_MINOR : TAM_LVL_NONE);

	// ==========================================================
	// One second tick
	always_ff @(posedge clk_in)
	begin
		if (srst_in || (tick_cnt_q == 26'(TICK_CYC - 1)))
			tick_cnt_q <= 26'h0000000;
		else
			tick_cnt_q <= tick_cnt_q + 26'h0000001;
	end

	always_ff @(posedge clk_in)
	begin
		tick_q <= !srst_in && (tick_cnt_q == 26'(TICK_CYC - 1));
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			cfg_q[0]       <= '{code: TAM_L1_CODE_RST, dur: TAM_DUR_RST};
			cfg_q[1]       <= '{code: TAM_L2_CODE_RST, dur: TAM_DUR_RST};
			slip_cfg_q.thr <= TAM_SLTHR_RST;
			slip_cfg_q.hrs <= TAM_SLHRS_RST;
			self_clr_q     <= 1'b1;
			hook_sel_q     <= 1'b0;
		end
		else if (wr_done && !bad_wr)
		begin
			if (sel_l1)
				cfg_q[0] <= new_l1;
			if (sel_l2)
				cfg_q[1] <= new_l2;
			if (sel_slip)
			begin
				slip_cfg_q.thr <= new_thr;
				slip_cfg_q.hrs <= new_hrs;
			end
			if (sel_ctrl)
			begin
				self_clr_q <= pwdata_in[TAM_CTRL_SELF];
				hook_sel_q <= pwdata_in[TAM_CTRL_SW];
			end
		end
	end

	// Sticky invalid flag, set wins over clear
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			inval_q <= 1'b0;
		else if (wr_reject)
			inval_q <= 1'b1;
		else if (inval_clr)
			inval_q <= 1'b0;
	end

	// ==========================================================
	// Per level error windows and alarm state
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (srst_in || op_clear)
			begin
				err_cnt_q[i] <= 32'h0000_0000;
				win_sec_q[i] <= 12'h000;
				act_q[i]     <= 1'b0;
				cond_q[i]    <= 1'b0;
			end
			else if (trig[i])
			begin
				err_cnt_q[i] <= 32'h0000_0000;
				win_sec_q[i] <= 12'h000;
				act_q[i]     <= 1'b1;
				cond_q[i]    <= 1'b1;
			end
			else if (win_end[i])
			begin
				err_cnt_q[i] <= {31'h0000_0000, bit_err_in};
				win_sec_q[i] <= 12'h000;
				cond_q[i]    <= 1'b0;
				if (self_clr_q)
					act_q[i] <= 1'b0;
			end
			else
			begin
				if (bit_err_in && (err_cnt_q[i] != 32'hffff_ffff))
					err_cnt_q[i] <= err_cnt_q[i] + 32'h0000_0001;
				if (tick_q)
					win_sec_q[i] <= win_sec_q[i] + 12'h001;
			end
		end
	end

	// ==========================================================
	// Frame slip counting period
	always_ff @(posedge clk_in)
	begin
		if (srst_in || op_clear || slip_end)
		begin
			slip_cnt_q <= 8'h00;
			slip_sec_q <= 12'h000;
			slip_hr_q  <= 5'h00;
		end
		else
		begin
			if (slip_over)
				slip_cnt_q <= 8'h00;
			else if (slip_in && (slip_cnt_q != 8'hff))
				slip_cnt_q <= slip_cnt_q + 8'h01;
			if (tick_q)
			begin
				if (slip_sec_q == TAM_SEC_PER_HR - 12'h001)
				begin
					slip_sec_q <= 12'h000;
					slip_hr_q  <= slip_hr_q + 5'h01;
				end
				else
					slip_sec_q <= slip_sec_q + 12'h001;
			end
		end
	end

	// ==========================================================
	// Log events
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			log_alarm_q <= 1'b0;
			log_lvl_q   <= 2'h0;
			log_clear_q <= 1'b0;
		end
		else
		begin
			log_alarm_q <= !op_clear && rise_any;
			log_lvl_q   <= trig[1] ? 2'(TAM_LVL_MAJOR) : 2'(TAM_LVL_MINOR);
			log_clear_q <= (act_q[0] || act_q[1]) && (op_clear ||
				(self_clr_q && ((act_q[0] && win_end[0] && !trig[0] && !act_q[1]) ||
				(act_q[1] && win_end[1] && !trig[1] && !act_q[0]) ||
				(win_end[0] && win_end[1] && !trig[0] && !trig[1]))));
		end
	end

	// ==========================================================
	// APB answer, one wait state
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= apb_acc && !pready_q;
			pslverr_q <= apb_acc && !pready_q && (!sel_any || bad_wr);
			if (apb_acc && !pready_q && !pwrite_in)
			begin
				case (1'b1)
					sel_l1:   prdata_q <= {4'h0, cfg_q[0].dur, 12'h000, cfg_q[0].code};
					sel_l2:   prdata_q <= {4'h0, cfg_q[1].dur, 12'h000, cfg_q[1].code};
					sel_slip: prdata_q <= {19'h00000, slip_cfg_q.hrs, slip_cfg_q.thr};
					sel_ctrl: prdata_q <= {29'h00000000, hook_sel_q, 1'b0, self_clr_q};
					sel_stat: prdata_q <= {23'h000000, inval_q, cond_q[1], cond_q[0],
						line_proc_out, red_led_out, contact_out, 1'b0, level};
					sel_c1:   prdata_q <= err_cnt_q[0];
					sel_c2:   prdata_q <= err_cnt_q[1];
					sel_sc:   prdata_q <= {24'h000000, slip_cnt_q};
					default:  prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Outputs
	assign pready_out        = pready_q;
	assign pslverr_out       = pslverr_q;
	assign prdata_out        = prdata_q;
	assign contact_out       = act_q[0] || act_q[1];
	assign red_led_out       = act_q[0] || act_q[1];
	assign line_proc_out     = act_q[1] && cond_q[1];
	assign yellow_out        = act_q[1] && cond_q[1];
	assign hook_off_out      = hook_sel_q;
	assign alarm_level_out   = level;
	assign log_alarm_out     = log_alarm_q;
	assign log_alarm_lvl_out = log_lvl_q;
	assign log_clear_out     = log_clear_q;

endmodule : tam_alarm_monitor

// >>> pkg/tam_pkg.sv
package tam_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] TAM_OFS_L1_CFG   = 8'h00;
	localparam logic [7:0] TAM_OFS_L2_CFG   = 8'h04;
	localparam logic [7:0] TAM_OFS_SLIP_CFG = 8'h08;
	localparam logic [7:0] TAM_OFS_CTRL     = 8'h0c;
	localparam logic [7:0] TAM_OFS_STATUS   = 8'h10;
	localparam logic [7:0] TAM_OFS_L1_CNT   = 8'h14;
	localparam logic [7:0] TAM_OFS_L2_CNT   = 8'h18;
	localparam logic [7:0] TAM_OFS_SLIP_CNT = 8'h1c;

	// ==========================================================
	// Field positions
	localparam int TAM_CODE_LSB  = 0;
	localparam int TAM_DUR_LSB   = 16;
	localparam int TAM_SLTHR_LSB = 0;
	localparam int TAM_SLHRS_LSB = 8;
	localparam int TAM_CTRL_SELF = 0;
	localparam int TAM_CTRL_CLR  = 1;
	localparam int TAM_CTRL_SW   = 2;
	localparam int TAM_ST_INVAL  = 8;

	// ==========================================================
	// Limits and reset values
	localparam logic [3:0]  TAM_CODE_MIN   = 4'h3;
	localparam logic [3:0]  TAM_CODE_MAX   = 4'h9;
	localparam logic [11:0] TAM_DUR_MAX    = 12'he10;
	localparam logic [4:0]  TAM_HRS_MAX    = 5'h18;
	localparam logic [3:0]  TAM_L1_CODE_RST = 4'h6;
	localparam logic [3:0]  TAM_L2_CODE_RST = 4'h5;
	localparam logic [11:0] TAM_DUR_RST    = 12'h00a;
	localparam logic [7:0]  TAM_SLTHR_RST  = 8'h05;
	localparam logic [4:0]  TAM_SLHRS_RST  = 5'h02;
	localparam logic [11:0] TAM_SEC_PER_HR = 12'he10;

	// ==========================================================
	// Timing
	localparam int TAM_CLK_HZ     = 50_000_000;
	localparam int TAM_TICK_S     = 1;
	localparam int TAM_TICK_CYC   = TAM_CLK_HZ * TAM_TICK_S;

	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		TAM_LVL_NONE,
		TAM_LVL_MINOR,
		TAM_LVL_MAJOR
	} tam_level_e;

	typedef struct packed
	{
		logic [3:0]  code;
		logic [11:0] dur;
	} tam_cfg_s;

	typedef struct packed
	{
		logic [7:0] thr;
		logic [4:0] hrs;
	} tam_slip_cfg_s;

endpackage : tam_pkg

// >>> bench/tam_alarm_monitor_asserts.sv
module tam_alarm_monitor_chk
	import tam_pkg::*;
#(
	parameter int TICK_CYC = TAM_TICK_CYC
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// APB
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [31:0] prdata_out,
	input  wire logic        pready_out,
	input  wire logic        pslverr_out,
	// Alarm side
	input  wire logic        contact_out,
	input  wire logic        red_led_out,
	input  wire logic        yellow_out,
	input  wire logic        line_proc_out,
	input  wire logic [1:0]  alarm_level_out,
	input  wire logic        log_alarm_out,
	input  wire logic [1:0]  log_alarm_lvl_out,
	input  wire logic        log_clear_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// ==========================================================
	// Alarm outputs
	AST_QUIET_AT_NONE: assert property (alarm_level_out == 2'h0 |-> !contact_out && !line_proc_out && !yellow_out)
		else $error("alarm output while level none");
	AST_LED_TRACKS_CONTACT: assert property (red_led_out == contact_out)
		else $error("led differs from contact");
	AST_CONTACT_NEEDS_LEVEL: assert property (contact_out |-> alarm_level_out != 2'h0)
		else $error("contact closed at level none");
	AST_ALARM_LOGGED: assert property (alarm_level_out != 2'h0 && $past(alarm_level_out) == 2'h0 && !$past(srst_in)
		|-> ##[0:1] (log_alarm_out && log_alarm_lvl_out != 2'h0)) else $error("alarm entry not logged");
	AST_YELLOW_TRACKS_LINE: assert property (yellow_out == line_proc_out)
		else $error("yellow differs from line processing");
	AST_LINE_NEEDS_MAJOR: assert property (line_proc_out |-> alarm_level_out == 2'h2 && contact_out)
		else $error("line processing without major alarm");
	AST_CLEAR_LOGGED: assert property ($fell(contact_out) && !$past(srst_in) |-> ##[0:1] log_clear_out)
		else $error("clear not logged");

	// ==========================================================
	// Register bus
	AST_BAD_CODE_REFUSED: assert property (pready_out && pwrite_in && pwdata_in[3:0] > TAM_CODE_MAX &&
		(paddr_in == TAM_OFS_L1_CFG || paddr_in == TAM_OFS_L2_CFG) |-> pslverr_out) else $error("bad code taken");
	AST_ONE_WAIT_STATE: assert property (psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out)
		else $error("ready not in second access cycle");
	AST_UNMAPPED_ERR: assert property (pready_out && paddr_in > TAM_OFS_SLIP_CNT |-> pslverr_out && prdata_out == 32'h0)
		else $error("unmapped access not refused");
endmodule : tam_alarm_monitor_chk

bind tam_alarm_monitor tam_alarm_monitor_chk #(.TICK_CYC(TICK_CYC)) u_chk (.clk_in(clk_in), .srst_in(srst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .contact_out(contact_out),
	.red_led_out(red_led_out), .yellow_out(yellow_out), .line_proc_out(line_proc_out),
	.alarm_level_out(alarm_level_out), .log_alarm_out(log_alarm_out), .log_alarm_lvl_out(log_alarm_lvl_out),
	.log_clear_out(log_clear_out));

// >>> bench/tam_carrier_model.sv
module tam_carrier_model
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// Burst request
	input  wire logic        go_in,
	input  wire logic [15:0] count_in,
	input  wire logic        slip_mode_in,
	input  wire logic [3:0]  gap_in,
	// Line events
	output logic             bit_err_out,
	output logic             slip_out,
	output logic             busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] left_q;
	logic [3:0]  wait_q;
	logic        mode_q;

	// ==========================================================
	// One-cycle event pulses, gap idle cycles apart
	assign busy_out = (left_q != 16'h0000);

	always_ff @(posedge clk_in)
	begin
		bit_err_out <= 1'b0;
		slip_out    <= 1'b0;
		if (srst_in)
			left_q <= 16'h0000;
		else if (go_in)
		begin
			left_q <= count_in;
			wait_q <= 4'h0;
			mode_q <= slip_mode_in;
		end
		else if (busy_out && wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
		else if (busy_out)
		begin
			left_q      <= left_q - 16'h0001;
			wait_q      <= gap_in;
			bit_err_out <= !mode_q;
			slip_out    <= mode_q;
		end
	end
endmodule : tam_carrier_model

// >>> bench/tb_top.sv
module tb_top;
	import tam_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, bit_err_in, slip_in;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rdata;
	logic rerr, contact_out, red_led_out, yellow_out, line_proc_out, hook_off_out, go, smode, busy;
	logic [1:0] alarm_level_out;
	logic [15:0] cnt;
	logic [3:0] gap;
	int err_total = 0;
	int samples_checked = 0;

	tam_alarm_monitor #(.TICK_CYC(20)) DUT (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .bit_err_in(bit_err_in),
		.slip_in(slip_in), .contact_out(contact_out), .red_led_out(red_led_out), .yellow_out(yellow_out),
		.line_proc_out(line_proc_out), .hook_off_out(hook_off_out), .alarm_level_out(alarm_level_out),
		.log_alarm_out(), .log_alarm_lvl_out(), .log_clear_out());
	tam_carrier_model u_line (.clk_in(clk_in), .srst_in(srst_in), .go_in(go), .count_in(cnt),
		.slip_mode_in(smode), .gap_in(gap), .bit_err_out(bit_err_in), .slip_out(slip_in), .busy_out(busy));

	// ==========================================================
	// Shared tasks
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_in   <= 1'b1;
		pwrite_in <= wr;
		paddr_in  <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		@(posedge clk_in);
		while (pready_out !== 1'b1)
		begin
			n++;
			@(posedge clk_in);
		end
		rdata = prdata_out;
		rerr  = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
		chk(32'(n), 32'h1, "apb wait states");
		@(posedge clk_in);
	endtask : apb

	function automatic logic [1:0] pick(input int sel);
		return (sel == 0) ? alarm_level_out : (sel == 1) ? {1'b0, line_proc_out} : {1'b0, contact_out};
	endfunction : pick

	task automatic wait_sig(input int sel, input logic [1:0] v, input int lim);
		int n;
		n = 0;
		while (pick(sel) !== v && n < lim)
		begin
			n++;
			@(posedge clk_in);
		end
		chk({30'h0, pick(sel)}, {30'h0, v}, "awaited output");
	endtask : wait_sig

	task automatic burst(input logic [15:0] c, input logic m, input logic [3:0] g);
		int n;
		n = 0;
		go    <= 1'b1;
		cnt   <= c;
		smode <= m;
		gap   <= g;
		@(posedge clk_in);
		go <= 1'b0;
		@(posedge clk_in);
		while (busy === 1'b1 && n < 20000)
		begin
			n++;
			@(posedge clk_in);
		end
		chk({31'h0, busy}, 32'h0, "burst drained");
		repeat (3) @(posedge clk_in);
	endtask : burst

	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		apb(1'b0, TAM_OFS_L1_CFG, 32'h0);
		chk(rdata, 32'h000a0006, "l1 defaults");
		apb(1'b0, TAM_OFS_L2_CFG, 32'h0);
		chk(rdata, 32'h000a0005, "l2 defaults");
		apb(1'b0, TAM_OFS_SLIP_CFG, 32'h0);
		chk(rdata, 32'h00000205, "slip defaults");
		apb(1'b0, TAM_OFS_CTRL, 32'h0);
		chk(rdata, 32'h00000001, "self clear default");
		apb(1'b0, TAM_OFS_STATUS, 32'h0);
		chk(rdata, 32'h00000000, "quiet status");
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped refused");
	endtask : t_defaults

	task automatic t_invalid();
		logic [31:0] bad [4] = '{32'h000a0002, 32'h000a000a, 32'h00160003, 32'h00090007};
		foreach (bad[i])
		begin
			apb(1'b1, TAM_OFS_L1_CFG, bad[i]);
			chk({31'h0, rerr}, 32'h1, "bad setting refused");
		end
		apb(1'b0, TAM_OFS_STATUS, 32'h0);
		chk({31'h0, rdata[TAM_ST_INVAL]}, 32'h1, "invalid flag");
		apb(1'b1, TAM_OFS_STATUS, 32'h00000100);
		apb(1'b1, TAM_OFS_L2_CFG, 32'h00150003);
		chk({31'h0, rerr}, 32'h0, "edge duration taken");
		apb(1'b1, TAM_OFS_L2_CFG, 32'h000a0005);
		apb(1'b0, TAM_OFS_STATUS, 32'h0);
		chk(rdata, 32'h0, "invalid flag cleared");
	endtask : t_invalid

	task automatic t_minor();
		burst(16'd40, 1'b0, 4'h0);
		wait_sig(0, 2'h1, 20);
		chk({29'h0, contact_out, red_led_out, yellow_out}, 32'h6, "minor outputs");
		repeat (100) @(posedge clk_in);
		chk({31'h0, contact_out}, 32'h1, "alarm lasts window");
		wait_sig(0, 2'h0, 700);
	endtask : t_minor

	task automatic t_major();
		apb(1'b1, TAM_OFS_CTRL, 32'h00000005);
		burst(16'd400, 1'b0, 4'h0);
		wait_sig(0, 2'h2, 20);
		chk({29'h0, line_proc_out, yellow_out, hook_off_out}, 32'h7, "major outputs");
		wait_sig(2, 2'h0, 1000);
	endtask : t_major

	task automatic t_manual();
		apb(1'b1, TAM_OFS_CTRL, 32'h00000000);
		burst(16'd400, 1'b0, 4'h0);
		wait_sig(0, 2'h2, 20);
		chk({31'h0, hook_off_out}, 32'h0, "all on hook");
		wait_sig(1, 2'h0, 1000);
		chk({30'h0, contact_out, yellow_out}, 32'h2, "contact held");
		repeat (300) @(posedge clk_in);
		chk({31'h0, red_led_out}, 32'h1, "no self clear");
		apb(1'b1, TAM_OFS_CTRL, 32'h00000002);
		wait_sig(2, 2'h0, 5);
	endtask : t_manual

	task automatic t_slip();
		apb(1'b1, TAM_OFS_CTRL, 32'h00000005);
		apb(1'b1, TAM_OFS_SLIP_CFG, 32'h00000101);
		burst(16'd1, 1'b1, 4'h0);
		chk({30'h0, alarm_level_out}, 32'h0, "slips at threshold");
		burst(16'd1, 1'b1, 4'h3);
		wait_sig(0, 2'h2, 20);
		apb(1'b1, TAM_OFS_CTRL, 32'h00000007);
		wait_sig(0, 2'h0, 5);
		burst(16'd1, 1'b1, 4'h0);
		repeat (72100) @(posedge clk_in);
		burst(16'd1, 1'b1, 4'h0);
		chk({30'h0, alarm_level_out}, 32'h0, "slip count restarted");
	endtask : t_slip

	task automatic t_rate();
		apb(1'b1, TAM_OFS_L1_CFG, 32'h000a0007);
		apb(1'b1, TAM_OFS_CTRL, 32'h00000003);
		burst(16'd1, 1'b0, 4'h0);
		chk({30'h0, alarm_level_out}, 32'h0, "one error at code 7");
		burst(16'd1, 1'b0, 4'h0);
		wait_sig(0, 2'h1, 20);
		apb(1'b1, TAM_OFS_CTRL, 32'h00000003);
		wait_sig(2, 2'h0, 5);
		apb(1'b1, TAM_OFS_L1_CFG, 32'h000a0006);
	endtask : t_rate

	task automatic t_keep();
		apb(1'b1, TAM_OFS_L2_CFG, 32'h00140000);
		apb(1'b0, TAM_OFS_L2_CFG, 32'h0);
		chk(rdata, 32'h00140005, "code kept");
		apb(1'b1, TAM_OFS_SLIP_CFG, 32'h00000300);
		apb(1'b0, TAM_OFS_SLIP_CFG, 32'h0);
		chk(rdata, 32'h00000301, "threshold kept");
	endtask : t_keep

	// ==========================================================
	// Clock, watchdog and main sequence
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	initial
	begin
		#2000000;
		err_total++;
		test_done();
	end

	initial
	begin
		{srst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {1'b1, 43'h0};
		{go, smode, cnt, gap} = 22'h0;
		repeat (6) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		t_defaults();
		t_invalid();
		t_minor();
		t_major();
		t_manual();
		t_rate();
		t_slip();
		t_keep();
		test_done();
	end
endmodule : tb_top
